// File: design/rsp_regs.svh
// register offsets, field positions, reset values and timing counts of the pin mux
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

// apb address width and register byte offsets
`define RSP_ADDR_W 8
`define RSP_OFF_CTRL 8'h00
`define RSP_OFF_FLAG_DIR 8'h04
`define RSP_OFF_FLAG_OUT 8'h08
`define RSP_OFF_FLAG_IN 8'h0c
`define RSP_OFF_MODE 8'h10
`define RSP_OFF_INT_STAT 8'h14
`define RSP_OFF_INT_MASK 8'h18

// control register fields
`define RSP_CTRL_W 3
`define RSP_CTRL_SP_ALT 0
`define RSP_CTRL_CFG_EDGE 1
`define RSP_CTRL_ALT_EDGE 2

// flag registers: bits 3:0 prog flags, 6:4 interrupt pins, 7 serial flag
`define RSP_FLAG_W 8
`define RSP_FLAG_SER 7

// mode register fields: 3:0 straps, 4 memory mode, 5 capture done
`define RSP_MODE_MEM_BIT 4
`define RSP_MODE_DONE_BIT 5

// interrupt status and mask bit positions
`define RSP_INT_W 5
`define RSP_INT_CFG 0
`define RSP_INT_LVL1 1
`define RSP_INT_EDGE 2
`define RSP_INT_ALT0 3
`define RSP_INT_ALT1 4

// reset values
`define RSP_CTRL_RST 3'h0
`define RSP_FLAG_DIR_RST 8'h00
`define RSP_FLAG_OUT_RST 8'hff
`define RSP_INT_MASK_RST 5'h00

// edges after reset release before strap levels leave the synchroniser
`define RSP_STRAP_SYNC_CYCLES 2'h2

`endif

// File: design/rsp_pkg.sv
// types shared by the pin mux modules
`default_nettype none
package rsp_pkg;
  // strap capture progress
  typedef enum logic {RSP_ST_HOLD, RSP_ST_RUN} rsp_strap_e;
  // memory interface mode, full memory first so it encodes as zero
  typedef enum logic {RSP_MEM_FULL, RSP_MEM_HOST} rsp_mem_mode_e;
  // captured strap levels, mode a in bit 0
  typedef struct packed {
    logic modeD;
    logic modeC;
    logic modeB;
    logic modeA;
  } rsp_straps_s;
endpackage
`default_nettype wire

// File: design/rsp_reg_if.sv
// interface between the register slave and the pin mux core
`timescale 1ns/1ns
`default_nettype none
`include "rsp_regs.svh"
interface rsp_reg_if;
  import rsp_pkg::*;
  logic [`RSP_CTRL_W-1:0] ctrl; // serial alternate and sense selects
  logic [`RSP_FLAG_W-1:0] flagDir; // flag drive enables
  logic [`RSP_FLAG_W-1:0] flagOut; // flag output levels
  logic [`RSP_FLAG_W-1:0] flagIn; // synchronised flag levels
  logic [`RSP_INT_W-1:0] intMask; // interrupt mask
  logic [`RSP_INT_W-1:0] intEvt; // interrupt events, one bit each
  rsp_straps_s straps; // captured straps
  rsp_mem_mode_e memMode; // captured memory mode
  logic strapDone; // straps captured
  modport regs (output ctrl, flagDir, flagOut, intMask,
                input flagIn, intEvt, straps, memMode, strapDone);
  modport core (input ctrl, flagDir, flagOut, intMask,
                output flagIn, intEvt, straps, memMode, strapDone);
endinterface
`default_nettype wire

// File: design/rsp_pin_cell.sv
// pad cell: two-flop input synchroniser and registered drive
`timescale 1ns/1ns
`default_nettype none
module rsp_pin_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pad side
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  // core side
  input wire logic driveEn,
  input wire logic driveVal,
  output logic syncIn
);
  logic meta_reg, meta_next; // first stage, read only by second
  logic sync_reg, sync_next; // second stage
  logic out_reg, out_next; // driven level
  logic oe_reg, oe_next; // drive enable

  // next values
  always_comb begin
    meta_next = padIn;
    sync_next = meta_reg;
    out_next = driveVal;
    oe_next = driveEn;
  end

  // registers; pad stays undriven in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign syncIn = sync_reg;
  assign padOut = out_reg;
  assign padOe = oe_reg;
endmodule
`default_nettype wire

// File: design/rsp_apb_regs.sv
// apb register slave with sticky interrupt status
`timescale 1ns/1ns
`default_nettype none
`include "rsp_regs.svh"
module rsp_apb_regs import rsp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RSP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt line
  output logic irq,
  // core side
  rsp_reg_if.regs rif
);
  logic [`RSP_CTRL_W-1:0] ctrl_reg, ctrl_next; // control
  logic [`RSP_FLAG_W-1:0] dir_reg, dir_next; // flag directions
  logic [`RSP_FLAG_W-1:0] fout_reg, fout_next; // flag outputs
  logic [`RSP_INT_W-1:0] stat_reg, stat_next; // sticky status
  logic [`RSP_INT_W-1:0] mask_reg, mask_next; // interrupt mask
  logic [31:0] rdata_reg, rdata_next; // read data
  logic ready_reg, ready_next; // access phase answer
  logic err_reg, err_next; // unmapped address
  logic irq_reg, irq_next; // interrupt line
  logic wrHit; // write completes this edge

  // decode in setup, act at the access edge
  always_comb begin
    ctrl_next = ctrl_reg;
    dir_next = dir_reg;
    fout_next = fout_reg;
    mask_next = mask_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    ready_next = 1'b0;
    wrHit = psel && penable && ready_reg && pwrite && !err_reg;
    // hardware set always lands, even beside a clear
    stat_next = stat_reg | rif.intEvt;
    if (psel && !penable) begin
      // read data registered here so it is stable through the access phase
      ready_next = 1'b1;
      err_next = 1'b0;
      rdata_next = 32'h0;
      if (paddr == `RSP_OFF_CTRL) begin
        rdata_next = 32'(ctrl_reg);
      end else if (paddr == `RSP_OFF_FLAG_DIR) begin
        rdata_next = 32'(dir_reg);
      end else if (paddr == `RSP_OFF_FLAG_OUT) begin
        rdata_next = 32'(fout_reg);
      end else if (paddr == `RSP_OFF_FLAG_IN) begin
        rdata_next = 32'(rif.flagIn);
      end else if (paddr == `RSP_OFF_MODE) begin
        rdata_next = 32'({rif.strapDone, rif.memMode, rif.straps});
      end else if (paddr == `RSP_OFF_INT_STAT) begin
        rdata_next = 32'(stat_reg);
      end else if (paddr == `RSP_OFF_INT_MASK) begin
        rdata_next = 32'(mask_reg);
      end else begin
        err_next = 1'b1;
      end
    end
    if (wrHit) begin
      // writes to read-only registers are dropped quietly
      if (paddr == `RSP_OFF_CTRL) begin
        ctrl_next = pwdata[`RSP_CTRL_W-1:0];
      end else if (paddr == `RSP_OFF_FLAG_DIR) begin
        dir_next = pwdata[`RSP_FLAG_W-1:0];
      end else if (paddr == `RSP_OFF_FLAG_OUT) begin
        fout_next = pwdata[`RSP_FLAG_W-1:0];
      end else if (paddr == `RSP_OFF_INT_STAT) begin
        stat_next = (stat_reg & ~pwdata[`RSP_INT_W-1:0]) | rif.intEvt;
      end else if (paddr == `RSP_OFF_INT_MASK) begin
        mask_next = pwdata[`RSP_INT_W-1:0];
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `RSP_CTRL_RST;
      dir_reg <= `RSP_FLAG_DIR_RST;
      fout_reg <= `RSP_FLAG_OUT_RST;
      stat_reg <= 5'h00;
      mask_reg <= `RSP_INT_MASK_RST;
      rdata_reg <= 32'h0;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      dir_reg <= dir_next;
      fout_reg <= fout_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
      irq_reg <= irq_next;
    end
  end

  assign rif.ctrl = ctrl_reg;
  assign rif.flagDir = dir_reg;
  assign rif.flagOut = fout_reg;
  assign rif.intMask = mask_reg;
  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// File: design/rsp_pin_mux.sv
// reset strap capture and function select for multiplexed pins
// What this block does
// R1 - straps sampled at reset, then flag pins
// R2 - memory mode fixed until next reset
// R3 - strap zero full memory, one host
// R4 - full enables byte dma, host enables host port
// R5 - shared pins carry only the selected signal
// R6 - bus pins at reset, serial pins anytime
// R7 - interrupt pins work as flags simultaneously
// R8 - configurable, level and edge interrupt sensing
// R9 - serial port becomes interrupts and flags
// R10 - reconfigurable pins start in primary function
`timescale 1ns/1ns
`default_nettype none
`include "rsp_regs.svh"
module rsp_pin_mux import rsp_pkg::*; #(
  parameter int SHARED_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RSP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt to the processor
  output logic irq,
  // mode straps and programmable flag pins
  input wire logic [3:0] progFlagIn,
  output logic [3:0] progFlagOut,
  output logic [3:0] progFlagOe,
  // interrupt and flag pins, asserted low
  input wire logic extIntConfigurableIn,
  output logic extIntConfigurableOut,
  output logic extIntConfigurableOe,
  input wire logic extIntLevelOneIn,
  output logic extIntLevelOneOut,
  output logic extIntLevelOneOe,
  input wire logic extIntEdgeIn,
  output logic extIntEdgeOut,
  output logic extIntEdgeOe,
  // second serial port pins: rx data, tx data, rx frame, tx frame
  input wire logic [3:0] serPinIn,
  output logic [3:0] serPinOut,
  output logic [3:0] serPinOe,
  // serial clock
  input wire logic serialClkInt,
  output logic serialClkOut,
  // serial port core side
  input wire logic spTxData,
  input wire logic spTxOe,
  input wire logic spRfsOut,
  input wire logic spRfsOe,
  input wire logic spTfsOut,
  input wire logic spTfsOe,
  output logic spRxData,
  output logic spRfsIn,
  output logic spTfsIn,
  // shared memory interface pins
  input wire logic [SHARED_W-1:0] sharedPinIn,
  output logic [SHARED_W-1:0] sharedPinOut,
  output logic [SHARED_W-1:0] sharedPinOe,
  // memory and host port core side
  input wire logic [SHARED_W-1:0] memAddr,
  input wire logic [SHARED_W-1:0] hostAdOut,
  input wire logic [SHARED_W-1:0] hostAdOe,
  output logic [SHARED_W-1:0] hostAdIn,
  // mode status
  output logic byteDmaEn,
  output logic hostPortEn,
  output logic fullAddrEn
);
  // pin indices inside the pad vectors
  localparam int PIN_CFG = 4;
  localparam int PIN_LVL1 = 5;
  localparam int PIN_EDGE = 6;
  localparam int PIN_SDR = 7;
  localparam int PIN_SDT = 8;
  localparam int PIN_RFS = 9;
  localparam int PIN_TFS = 10;
  localparam int PIN_SH = 11;
  localparam int NPIN = PIN_SH + SHARED_W;

  logic [NPIN-1:0] padIn; // raw pad levels
  logic [NPIN-1:0] padOut; // registered drive levels
  logic [NPIN-1:0] padOe; // registered drive enables
  logic [NPIN-1:0] syncIn; // synchronised pad levels
  logic [NPIN-1:0] driveEn; // requested drive enables
  logic [NPIN-1:0] driveVal; // requested drive levels

  rsp_reg_if rif ();

  // register slave
  rsp_apb_regs u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .rif(rif.regs)
  );

  // one pad cell per multiplexed pin
  assign padIn = {sharedPinIn, serPinIn, extIntEdgeIn, extIntLevelOneIn,
                  extIntConfigurableIn, progFlagIn};
  for (genvar gi = 0; gi < NPIN; gi++) begin : g_pad
    rsp_pin_cell u_cell (
      .clk(clk),
      .rst_b(rst_b),
      .padIn(padIn[gi]),
      .padOut(padOut[gi]),
      .padOe(padOe[gi]),
      .driveEn(driveEn[gi]),
      .driveVal(driveVal[gi]),
      .syncIn(syncIn[gi])
    );
  end

  // pad outputs straight from the cell flops
  assign progFlagOut = padOut[3:0];
  assign progFlagOe = padOe[3:0];
  assign extIntConfigurableOut = padOut[PIN_CFG];
  assign extIntConfigurableOe = padOe[PIN_CFG];
  assign extIntLevelOneOut = padOut[PIN_LVL1];
  assign extIntLevelOneOe = padOe[PIN_LVL1];
  assign extIntEdgeOut = padOut[PIN_EDGE];
  assign extIntEdgeOe = padOe[PIN_EDGE];
  assign serPinOut = padOut[PIN_TFS:PIN_SDR];
  assign serPinOe = padOe[PIN_TFS:PIN_SDR];
  assign sharedPinOut = padOut[NPIN-1:PIN_SH];
  assign sharedPinOe = padOe[NPIN-1:PIN_SH];

  // strap capture state
  rsp_strap_e state_reg, state_next; // hold until straps taken
  logic [1:0] cnt_reg, cnt_next; // synchroniser settle count
  rsp_straps_s straps_reg, straps_next; // captured straps
  rsp_mem_mode_e memMode_reg, memMode_next; // captured memory mode
  logic run; // straps captured, normal operation
  logic spAlt; // serial pins in system-control use

  assign run = (state_reg == RSP_ST_RUN);
  assign spAlt = rif.ctrl[`RSP_CTRL_SP_ALT];

  // capture the levels that stood on the straps while reset was held
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    straps_next = straps_reg;
    memMode_next = memMode_reg;
    case (state_reg)
      RSP_ST_HOLD: begin
        // wait for the reset-time level to clear both synchroniser stages
        if (cnt_reg == `RSP_STRAP_SYNC_CYCLES) begin
          straps_next = rsp_straps_s'(syncIn[3:0]); // R1
          memMode_next = syncIn[2] ? RSP_MEM_HOST : RSP_MEM_FULL; // R3
          state_next = RSP_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
      // no way back: only a new reset may change the mode
      RSP_ST_RUN: begin
        state_next = RSP_ST_RUN; // R2
      end
      default: begin
        state_next = RSP_ST_HOLD;
      end
    endcase
  end

  // strap registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= RSP_ST_HOLD;
      cnt_reg <= 2'h0;
      straps_reg <= 4'h0;
      memMode_reg <= RSP_MEM_FULL;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      straps_reg <= straps_next;
      memMode_reg <= memMode_next;
    end
  end

  assign rif.straps = straps_reg;
  assign rif.memMode = memMode_reg;
  assign rif.strapDone = run;
  // bit 7 reads the input flag only while the serial pins are in flag use
  assign rif.flagIn = {spAlt & syncIn[PIN_SDR], syncIn[PIN_EDGE:0]};

  // pad drive selection
  always_comb begin
    driveEn = '0;
    driveVal = '0;
    // straps stay undriven until captured, then plain flags
    driveEn[PIN_EDGE:0] = run ? rif.flagDir[PIN_EDGE:0] : 7'h00; // R1
    // interrupt pins may be driven as flags and still interrupt
    driveVal[PIN_EDGE:0] = rif.flagOut[PIN_EDGE:0]; // R7
    // serial pins follow the control bit at any time
    if (spAlt) begin
      driveEn[PIN_SDT] = 1'b1; // R9
      driveVal[PIN_SDT] = rif.flagOut[`RSP_FLAG_SER]; // R9
    end else begin
      driveEn[PIN_SDT] = spTxOe; // R6
      driveVal[PIN_SDT] = spTxData; // R10
      driveEn[PIN_RFS] = spRfsOe; // R10
      driveVal[PIN_RFS] = spRfsOut;
      driveEn[PIN_TFS] = spTfsOe; // R10
      driveVal[PIN_TFS] = spTfsOut;
    end
    // shared pins carry the signal of the captured mode only
    if (run && memMode_reg == RSP_MEM_FULL) begin
      driveEn[NPIN-1:PIN_SH] = '1; // R5
      driveVal[NPIN-1:PIN_SH] = memAddr; // R5
    end else if (run) begin
      driveEn[NPIN-1:PIN_SH] = hostAdOe; // R5
      driveVal[NPIN-1:PIN_SH] = hostAdOut;
    end
  end

  // core side registers
  logic byteDma_reg, byteDma_next; // byte dma enable
  logic hostPort_reg, hostPort_next; // host port enable
  logic fullAddr_reg, fullAddr_next; // full external addressing
  logic rxData_reg, rxData_next; // serial rx data to core
  logic rfs_reg, rfs_next; // rx frame to core
  logic tfs_reg, tfs_next; // tx frame to core
  logic sclk_reg, sclk_next; // serial clock out
  logic [SHARED_W-1:0] hostAd_reg, hostAd_next; // host port input

  // steer inputs to the core; the unused function sees an idle zero
  always_comb begin
    byteDma_next = run && (memMode_reg == RSP_MEM_FULL); // R4
    fullAddr_next = run && (memMode_reg == RSP_MEM_FULL); // R4
    hostPort_next = run && (memMode_reg == RSP_MEM_HOST); // R4
    hostAd_next = (run && memMode_reg == RSP_MEM_HOST) ? syncIn[NPIN-1:PIN_SH] : '0; // R5
    rxData_next = spAlt ? 1'b0 : syncIn[PIN_SDR]; // R9
    rfs_next = spAlt ? 1'b0 : syncIn[PIN_RFS];
    tfs_next = spAlt ? 1'b0 : syncIn[PIN_TFS];
    // internal serial clock stays usable in either configuration
    sclk_next = serialClkInt; // R9
  end

  // core side register bank
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byteDma_reg <= 1'b0;
      hostPort_reg <= 1'b0;
      fullAddr_reg <= 1'b0;
      hostAd_reg <= '0;
      rxData_reg <= 1'b0;
      rfs_reg <= 1'b0;
      tfs_reg <= 1'b0;
      sclk_reg <= 1'b0;
    end else begin
      byteDma_reg <= byteDma_next;
      hostPort_reg <= hostPort_next;
      fullAddr_reg <= fullAddr_next;
      hostAd_reg <= hostAd_next;
      rxData_reg <= rxData_next;
      rfs_reg <= rfs_next;
      tfs_reg <= tfs_next;
      sclk_reg <= sclk_next;
    end
  end

  assign byteDmaEn = byteDma_reg;
  assign hostPortEn = hostPort_reg;
  assign fullAddrEn = fullAddr_reg;
  assign hostAdIn = hostAd_reg;
  assign spRxData = rxData_reg;
  assign spRfsIn = rfs_reg;
  assign spTfsIn = tfs_reg;
  assign serialClkOut = sclk_reg;

  // interrupt sensing
  logic [`RSP_INT_W-1:0] lvl; // request asserted (pin low) per source
  logic [`RSP_INT_W-1:0] rise; // newly asserted this cycle
  logic [`RSP_INT_W-1:0] evt; // events to the status register
  logic [`RSP_INT_W-1:0] prev_reg, prev_next; // last cycle's requests

  // a driven pin is judged by what we drive, else by what arrives
  function automatic logic pinLow(input logic oe, input logic val, input logic syn);
    pinLow = oe ? !val : !syn;
  endfunction

  always_comb begin
    lvl[`RSP_INT_CFG] = pinLow(padOe[PIN_CFG], padOut[PIN_CFG], syncIn[PIN_CFG]); // R7
    lvl[`RSP_INT_LVL1] = pinLow(padOe[PIN_LVL1], padOut[PIN_LVL1], syncIn[PIN_LVL1]);
    lvl[`RSP_INT_EDGE] = pinLow(padOe[PIN_EDGE], padOut[PIN_EDGE], syncIn[PIN_EDGE]);
    lvl[`RSP_INT_ALT0] = spAlt && !syncIn[PIN_RFS]; // R9
    lvl[`RSP_INT_ALT1] = spAlt && !syncIn[PIN_TFS]; // R9
    rise = lvl & ~prev_reg;
    prev_next = lvl;
    // no events before the straps settle, the pins are still straps then
    evt = '0;
    if (run) begin
      evt[`RSP_INT_CFG] = rif.ctrl[`RSP_CTRL_CFG_EDGE] ? rise[`RSP_INT_CFG]
                                                      : lvl[`RSP_INT_CFG]; // R8
      evt[`RSP_INT_LVL1] = lvl[`RSP_INT_LVL1]; // R8
      evt[`RSP_INT_EDGE] = rise[`RSP_INT_EDGE]; // R8
      evt[`RSP_INT_ALT0] = rif.ctrl[`RSP_CTRL_ALT_EDGE] ? rise[`RSP_INT_ALT0]
                                                       : lvl[`RSP_INT_ALT0];
      evt[`RSP_INT_ALT1] = rif.ctrl[`RSP_CTRL_ALT_EDGE] ? rise[`RSP_INT_ALT1]
                                                       : lvl[`RSP_INT_ALT1];
    end
  end

  // previous request levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 5'h00;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rif.intEvt = evt;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_strap_pins_free: assert property ( // R1
    (state_reg == RSP_ST_HOLD) |=> (progFlagOe == 4'h0 && !extIntEdgeOe))
    else $error("strap pin driven before capture");

  a_mode_held: assert property ( // R2
    run && $past(run) |-> $stable(memMode_reg) && $stable(straps_reg))
    else $error("memory mode changed while running");

  a_mode_decode: assert property ( // R3
    $rose(run) |-> memMode_reg == (straps_reg.modeC ? RSP_MEM_HOST : RSP_MEM_FULL))
    else $error("memory mode does not match strap");

  a_dma_select: assert property ( // R4
    run ##1 run |-> byteDmaEn == (memMode_reg == RSP_MEM_FULL)
                    && hostPortEn == (memMode_reg == RSP_MEM_HOST) && fullAddrEn == byteDmaEn)
    else $error("dma enables disagree with mode");

  a_shared_owner: assert property ( // R5
    run && memMode_reg == RSP_MEM_FULL |=> sharedPinOe == '1
                                          && sharedPinOut == $past(memAddr) && hostAdIn == '0)
    else $error("shared pins not owned by memory address");

  a_serial_swap: assert property ( // R6
    spAlt ##1 spAlt |-> spRxData == 1'b0 && serPinOe[1] && serPinOut[1] == $past(rif.flagOut[7]))
    else $error("serial pins not in flag use");

  a_flag_vector: assert property ( // R7
    run && !rif.ctrl[`RSP_CTRL_CFG_EDGE] && lvl[`RSP_INT_CFG] && rif.intMask[`RSP_INT_CFG]
    |=> irq)
    else $error("unmasked interrupt pin did not raise irq");

  a_edge_once: assert property ( // R8
    run && lvl[`RSP_INT_EDGE] && $past(lvl[`RSP_INT_EDGE]) |-> !evt[`RSP_INT_EDGE])
    else $error("edge interrupt fired on a held level");

  a_alt_clock: assert property ( // R9
    spAlt |=> serialClkOut == $past(serialClkInt) && !serPinOe[2] && !serPinOe[3])
    else $error("serial clock or interrupt pins wrong in flag use");

  a_primary_default: assert property ( // R10
    !spAlt |=> serPinOut[1] == $past(spTxData) && serPinOe[2] == $past(spRfsOe))
    else $error("serial pins not in primary function");
endmodule
`default_nettype wire

// File: testbench/rsp_pin_env.sv
// pin-side model: mode straps, pull-ups and interrupting peripherals
`timescale 1ns/1ns
`default_nettype none
module rsp_pin_env (
  // strap drive and peripheral requests, a request pulls its pin low
  input wire logic strapEn,
  input wire logic [3:0] straps,
  input wire logic [6:0] extReq,
  // pins as the block drives them
  input wire logic [10:0] pinOut,
  input wire logic [10:0] pinOe,
  output logic [10:0] pinIn
);
  // after the strap window the inverse shows, so a late capture is caught
  always_comb begin
    pinIn[3:0] = strapEn ? straps : ~straps;
    pinIn[10:4] = ~extReq;
    for (int i = 0; i < 11; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
    end
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for strap capture and pin function select
`timescale 1ns/1ns
`default_nettype none
`include "rsp_regs.svh"
module testbench;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} rsp_row_s;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, strapEn, err;
  logic byteDmaEn, hostPortEn, fullAddrEn, spRxData, sclkOut, rfsIn, tfsIn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] straps, memAddr, sharedPinOut, shOe, hostAdIn;
  logic [6:0] extReq, sp;
  wire logic [10:0] pinOut, pinOe; // slices driven by several output ports
  logic [10:0] pinIn;
  int miscompares, num_checks, cyc;
  // reads after reset and the refusal cases, one transfer a row
  rsp_row_s rows [8] = '{'{0, `RSP_OFF_CTRL, 0, 0, 0}, '{0, `RSP_OFF_FLAG_DIR, 0, 0, 0},
    '{0, `RSP_OFF_FLAG_OUT, 0, 32'hff, 0}, '{0, `RSP_OFF_INT_MASK, 0, 0, 0},
    '{0, `RSP_OFF_MODE, 0, 32'h23, 0}, '{1, `RSP_OFF_MODE, 0, 0, 0},
    '{0, `RSP_OFF_MODE, 0, 32'h23, 0}, '{0, 8'h1c, 0, 0, 1}};
  rsp_pin_mux dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .progFlagIn(pinIn[3:0]), .progFlagOut(pinOut[3:0]), .progFlagOe(pinOe[3:0]),
    .extIntConfigurableIn(pinIn[4]), .extIntConfigurableOut(pinOut[4]),
    .extIntConfigurableOe(pinOe[4]), .extIntLevelOneIn(pinIn[5]), .extIntLevelOneOut(pinOut[5]),
    .extIntLevelOneOe(pinOe[5]), .extIntEdgeIn(pinIn[6]), .extIntEdgeOut(pinOut[6]),
    .extIntEdgeOe(pinOe[6]), .serPinIn(pinIn[10:7]), .serPinOut(pinOut[10:7]),
    .serPinOe(pinOe[10:7]), .serialClkInt(sp[6]), .serialClkOut(sclkOut), .spTxData(sp[0]),
    .spTxOe(sp[1]), .spRfsOut(sp[2]), .spRfsOe(sp[3]), .spTfsOut(sp[4]), .spTfsOe(sp[5]),
    .spRxData, .spRfsIn(rfsIn), .spTfsIn(tfsIn), .sharedPinIn(memAddr), .sharedPinOut,
    .sharedPinOe(shOe), .memAddr, .hostAdOut(~memAddr), .hostAdOe(memAddr), .hostAdIn,
    .byteDmaEn, .hostPortEn, .fullAddrEn);
  rsp_pin_env env_u (.strapEn, .straps, .extReq, .pinOut, .pinOe, .pinIn);
  // clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // straps stay driven through reset and four edges past release
  task automatic do_reset(input logic [3:0] s);
    rst_b <= 1'b0;
    strapEn <= 1'b1;
    straps <= s;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    strapEn <= 1'b0;
  endtask
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {extReq, memAddr, sp} <= {7'h0, 4'ha, 7'h2a};
    do_reset(4'h3);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) cmp(rd, rows[i].e);
      cmp(err, rows[i].er);
    end
    cmp({byteDmaEn, hostPortEn, fullAddrEn, sharedPinOut}, {3'h5, memAddr});
    apb(1, `RSP_OFF_FLAG_DIR, 32'h11);
    apb(1, `RSP_OFF_FLAG_OUT, 32'hee);
    apb(1, `RSP_OFF_INT_MASK, 32'h01);
    repeat (5) @(posedge clk);
    cmp({pinOe[3:0], pinOut[0], irq}, 6'h05);
    apb(0, `RSP_OFF_FLAG_IN, 0);
    cmp(rd & 32'h0e, 32'h0c);
    apb(0, `RSP_OFF_INT_STAT, 0);
    cmp(rd, 32'h01);
    // level pin held low stays pending after a clear, a held edge pin does not
    apb(1, `RSP_OFF_CTRL, 32'h02);
    apb(1, `RSP_OFF_FLAG_OUT, 32'hff);
    extReq <= 7'h06;
    repeat (6) @(posedge clk);
    apb(1, `RSP_OFF_INT_STAT, 32'h1f);
    apb(0, `RSP_OFF_INT_STAT, 0);
    cmp(rd, 32'h02);
    // serial pins switched at run time to interrupt and flag duty
    // alternate requests edge sensed, internal serial clock kept running
    apb(1, `RSP_OFF_CTRL, 32'h05);
    extReq <= 7'h20;
    repeat (6) @(posedge clk) sp[6] <= ~sp[6];
    apb(0, `RSP_OFF_INT_STAT, 0);
    cmp({rd[3], spRxData}, 2'h2);
    // a held request in edge mode does not come back after a clear
    apb(1, `RSP_OFF_INT_STAT, 32'h1f);
    apb(0, `RSP_OFF_INT_STAT, 0);
    cmp(rd, 32'h0);
    extReq <= 7'h00;
    do_reset(4'h4);
    apb(0, `RSP_OFF_MODE, 0);
    cmp(rd, 32'h34);
    cmp({byteDmaEn, hostPortEn, fullAddrEn}, 3'h2);
    apb(0, `RSP_OFF_CTRL, 0);
    cmp(rd, 32'h0);
    // host mode owns the shared pins, serial pins back in primary use
    cmp({sclkOut, rfsIn, tfsIn, shOe, sharedPinOut, hostAdIn, pinOe[10:7]}, 19'h0a5ae);
    final_report();
  end
endmodule
`default_nettype wire
